// ### pkg/posr_pkg.sv
// Package for the controller output signal router: register map, codes, reset values
package posr_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_OUTPUTS = 23;
  localparam int SEL_W = 6;
  localparam int NUM_SRC = 64;

  // ----------------------------------------------------------------
  // Selection codes
  // ----------------------------------------------------------------
  localparam logic [5:0] SEL_OFF = 6'h00;
  localparam logic [5:0] SEL_SWITCH_S3 = 6'h01;
  localparam logic [5:0] SEL_SWITCH_S4 = 6'h02;
  localparam logic [5:0] SEL_ECHO_STROBE = 6'h03;
  localparam logic [5:0] SEL_ECHO_BIT0 = 6'h04;
  localparam logic [5:0] SEL_TARE_WARN = 6'h0b;
  localparam logic [5:0] SEL_TOOL_WARN = 6'h0c;
  localparam logic [5:0] SEL_TOTAL_WARN = 6'h0d;
  localparam logic [5:0] SEL_SENSOR_TEST_PASS = 6'h0e;
  localparam logic [5:0] SEL_SIMPLE_TEST = 6'h0f;
  localparam logic [5:0] SEL_COMPLEX_TEST = 6'h10;
  localparam logic [5:0] SEL_MEASURING = 6'h11;
  localparam logic [5:0] SEL_CONFIG = 6'h12;
  localparam logic [5:0] SEL_ACK_ALARM = 6'h13;
  localparam logic [5:0] SEL_ACK_LOCK = 6'h14;
  localparam logic [5:0] SEL_ACK_PASS = 6'h15;
  localparam logic [5:0] SEL_ACK_FAIL = 6'h16;
  localparam logic [5:0] SEL_WINDOW1_FAIL = 6'h17;
  localparam logic [5:0] SEL_TRAP_X1_FAIL = 6'h21;
  localparam logic [5:0] SEL_THRESH1_FAIL = 6'h25;
  localparam logic [5:0] SEL_LAST = 6'h28;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SEL_BASE = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h60;
  localparam logic [7:0] ADDR_TOOL_LIMIT = 8'h64;
  localparam logic [7:0] ADDR_TOOL_COUNT = 8'h68;
  localparam logic [7:0] ADDR_TARE_LIMIT = 8'h6c;
  localparam logic [7:0] ADDR_TARE_VALUE = 8'h70;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h74;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h78;
  localparam logic [7:0] ADDR_OUT_STATE = 8'h7c;

  // Control register fields
  localparam int CTRL_CLR_TOOL = 0;
  localparam int CTRL_ACK_PASS_EN = 1;
  localparam int CTRL_ACK_FAIL_EN = 2;

  // Interrupt status bits
  localparam int IRQ_TOOL = 0;
  localparam int IRQ_TARE = 1;
  localparam int IRQ_TOTAL = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] TOOL_LIMIT_RESET = 32'hffffffff;
  localparam logic [31:0] TARE_LIMIT_RESET = 32'hffffffff;
  localparam int FLASH_HALF_NS = 250000000;
  localparam int CLK_NS = 5;
  localparam int FLASH_HALF_CYC = FLASH_HALF_NS / CLK_NS;

  typedef logic [5:0] posr_sel_type;

  localparam posr_sel_type [22:0] SEL_DEFAULT = '{
    SEL_COMPLEX_TEST, SEL_SIMPLE_TEST, SEL_TOTAL_WARN, SEL_TOOL_WARN, SEL_TARE_WARN,
    SEL_WINDOW1_FAIL, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h1d, 6'h1e,
    SEL_SWITCH_S4, SEL_SWITCH_S3, 6'h08, 6'h07, 6'h06, 6'h05, SEL_ECHO_BIT0,
    6'h1f, SEL_SENSOR_TEST_PASS, SEL_ECHO_STROBE};

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic switch_s3;
    logic switch_s4;
    logic [6:0] prog_number;
    logic prog_valid;
    logic [31:0] tare_value;
    logic measure_done;
    logic sensor_test_pass;
    logic simple_test_active;
    logic complex_test_active;
    logic measuring_now;
    logic config_mode;
    logic other_warning;
    logic ack_alarm;
    logic ack_lock;
    logic ack_pass;
    logic ack_fail;
    logic ack_pending_pass;
    logic ack_pending_fail;
    logic [9:0] window_fail;
    logic [3:0] trapezoid_fail;
    logic [3:0] threshold_fail;
  } posr_status_type;

  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } posr_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } posr_axi_rsp_type;

endpackage : posr_pkg

// ### core/posr_router.sv
// Controller output router: per-output signal selection, warnings, tool counter, AXI4-Lite
`timescale 1ns/1ps

// How it works
// - Each of 23 outputs has its own writable selection register.
// - Every output is driven by exactly one signal from the selectable set.
// - Selections reset to the factory assignment of the 23 outputs.
// - Echo bits carry the active program number, bit index equals weight.
// - Echo strobe is high only while echo bits are valid; controller samples then.
// - Composite warning is high whenever any device warning is active.
// - Tare warning rises once the tare value reaches its limit.
// - Tool warning rises once the tool counter reaches its limit.
// - Measuring output follows the start-measurement condition exactly.
// - Configuration output is high only in configuration mode.
// - Separate outputs show simple and complex test operation.
// - Window, trapezoid and threshold fail flags are each selectable.
// - Acknowledgement alarm, lock, pass and fail are each routable anywhere.
// - Tool counter counts each measurement outside a clear cycle; clearing it drops its warning unless the limit is 0.
// - Echo bits 5 and 6 are selectable too.
// - Pending acknowledgement makes its output flash until acknowledged.
module posr_router
  import posr_pkg::*;
#(
  parameter int OUTPUTS = NUM_OUTPUTS,
  parameter int FLASH_CYCLES = FLASH_HALF_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire posr_status_type status,
  input wire posr_axi_req_type axi_req,
  output posr_axi_rsp_type axi_rsp,
  output logic [OUTPUTS-1:0] plc_out,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    posr_sel_type [22:0] sel;
    logic [31:0] tool_count;
    logic [31:0] tool_limit;
    logic [31:0] tare_limit;
    logic ack_pass_en;
    logic ack_fail_en;
    logic [27:0] flash_cnt;
    logic flash;
    logic tool_warn;
    logic tare_warn;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [OUTPUTS-1:0] plc_out;
    logic irq;
    posr_axi_rsp_type rsp;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
  } posr_state_type;

  posr_state_type r;
  posr_state_type next_r;

  logic [NUM_SRC-1:0] src;
  logic total_warn;

  // ----------------------------------------------------------------
  // Selectable signal set
  // ----------------------------------------------------------------
  always_comb begin
    total_warn = r.tool_warn | r.tare_warn | status.other_warning;
    src = '0;
    src[SEL_SWITCH_S3] = status.switch_s3;
    src[SEL_SWITCH_S4] = status.switch_s4;
    src[SEL_ECHO_STROBE] = status.prog_valid;
    for (int i = 0; i < 7; i++) begin
      src[SEL_ECHO_BIT0 + i] = status.prog_number[i] & status.prog_valid;
    end
    src[SEL_TARE_WARN] = r.tare_warn;
    src[SEL_TOOL_WARN] = r.tool_warn;
    src[SEL_TOTAL_WARN] = total_warn;
    src[SEL_SENSOR_TEST_PASS] = status.sensor_test_pass;
    src[SEL_SIMPLE_TEST] = status.simple_test_active;
    src[SEL_COMPLEX_TEST] = status.complex_test_active;
    src[SEL_MEASURING] = status.measuring_now;
    src[SEL_CONFIG] = status.config_mode;
    src[SEL_ACK_ALARM] = status.ack_alarm;
    src[SEL_ACK_LOCK] = status.ack_lock;
    // Flash while waiting, steady result otherwise
    src[SEL_ACK_PASS] = (r.ack_pass_en & status.ack_pending_pass) ? r.flash
                        : status.ack_pass;
    src[SEL_ACK_FAIL] = (r.ack_fail_en & status.ack_pending_fail) ? r.flash
                        : status.ack_fail;
    for (int i = 0; i < 10; i++) begin
      src[SEL_WINDOW1_FAIL + i] = status.window_fail[i];
    end
    for (int i = 0; i < 4; i++) begin
      src[SEL_TRAP_X1_FAIL + i] = status.trapezoid_fail[i];
      src[SEL_THRESH1_FAIL + i] = status.threshold_fail[i];
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic do_write;
    logic do_read;
    logic [7:0] ra;
    logic [31:0] rd;
    logic clr_tool;
    logic [2:0] ev;
    next_r = r;
    do_write = 1'b0;
    do_read = 1'b0;
    ra = axi_req.araddr[7:0];
    rd = 32'h00000000;
    clr_tool = 1'b0;
    ev = 3'b000;

    // Registered mux, unknown codes fall to zero
    for (int o = 0; o < OUTPUTS; o++) begin
      next_r.plc_out[o] = (r.sel[o] <= SEL_LAST) ? src[r.sel[o]] : 1'b0;
    end

    // Flash divider
    if (r.flash_cnt >= 28'(FLASH_CYCLES - 1)) begin
      next_r.flash_cnt = '0;
      next_r.flash = ~r.flash;
    end else begin
      next_r.flash_cnt = r.flash_cnt + 28'h0000001;
    end

    // Write channel: address and data taken in either order
    if (axi_req.awvalid && !r.aw_held) begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = axi_req.awaddr[7:0];
    end
    if (axi_req.wvalid && !r.w_held) begin
      next_r.w_held = 1'b1;
      next_r.w_data = axi_req.wdata;
      next_r.w_strb = axi_req.wstrb;
    end
    next_r.rsp.awready = 1'b0;
    next_r.rsp.wready = 1'b0;
    if (!r.aw_held && axi_req.awvalid && !r.rsp.bvalid) begin
      next_r.rsp.awready = 1'b0;
    end
    if (r.rsp.bvalid && axi_req.bready) begin
      next_r.rsp.bvalid = 1'b0;
    end
    if (r.aw_held && r.w_held && !r.rsp.bvalid) begin
      do_write = 1'b1;
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.rsp.bvalid = 1'b1;
      next_r.rsp.bresp = 2'b00;
    end

    // Ready pulses: one-cycle acceptance of a held beat
    next_r.rsp.awready = axi_req.awvalid && !r.aw_held && !r.rsp.awready;
    next_r.rsp.wready = axi_req.wvalid && !r.w_held && !r.rsp.wready;
    if (!(axi_req.awvalid && !r.aw_held && !r.rsp.awready)) begin
      next_r.aw_held = r.aw_held;
    end
    if (!(axi_req.wvalid && !r.w_held && !r.rsp.wready)) begin
      next_r.w_held = r.w_held;
    end
    if (do_write) begin
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
    end

    if (do_write) begin
      if (r.aw_addr < ADDR_CTRL) begin
        if (r.aw_addr[1:0] == 2'b00 && r.aw_addr[7:2] < 6'(OUTPUTS) && r.w_strb[0]) begin
          next_r.sel[r.aw_addr[7:2]] = r.w_data[5:0];
        end else begin
          next_r.rsp.bresp = 2'b10;
        end
      end else if (r.aw_addr == ADDR_CTRL) begin
        clr_tool = r.w_data[CTRL_CLR_TOOL];
        next_r.ack_pass_en = r.w_data[CTRL_ACK_PASS_EN];
        next_r.ack_fail_en = r.w_data[CTRL_ACK_FAIL_EN];
      end else if (r.aw_addr == ADDR_TOOL_LIMIT) begin
        next_r.tool_limit = r.w_data;
      end else if (r.aw_addr == ADDR_TARE_LIMIT) begin
        next_r.tare_limit = r.w_data;
      end else if (r.aw_addr == ADDR_IRQ_MASK) begin
        next_r.irq_mask = r.w_data[2:0];
      end else begin
        next_r.rsp.bresp = 2'b10;
      end
    end

    // Read channel
    next_r.rsp.arready = axi_req.arvalid && !r.rsp.rvalid && !r.rsp.arready;
    if (r.rsp.rvalid && axi_req.rready) begin
      next_r.rsp.rvalid = 1'b0;
    end
    if (r.rsp.arready && axi_req.arvalid) begin
      do_read = 1'b1;
    end
    if (do_read) begin
      next_r.rsp.rresp = 2'b00;
      if (ra < ADDR_CTRL && ra[7:2] < 6'(OUTPUTS)) begin
        rd = {26'h0, r.sel[ra[7:2]]};
      end else if (ra == ADDR_CTRL) begin
        rd = {29'h0, r.ack_fail_en, r.ack_pass_en, 1'b0};
      end else if (ra == ADDR_TOOL_LIMIT) begin
        rd = r.tool_limit;
      end else if (ra == ADDR_TOOL_COUNT) begin
        rd = r.tool_count;
      end else if (ra == ADDR_TARE_LIMIT) begin
        rd = r.tare_limit;
      end else if (ra == ADDR_TARE_VALUE) begin
        rd = status.tare_value;
      end else if (ra == ADDR_IRQ_STATUS) begin
        rd = {29'h0, r.irq_status};
      end else if (ra == ADDR_IRQ_MASK) begin
        rd = {29'h0, r.irq_mask};
      end else if (ra == ADDR_OUT_STATE) begin
        rd = 32'(r.plc_out);
      end else begin
        next_r.rsp.rresp = 2'b10;
      end
      next_r.rsp.rdata = rd;
      next_r.rsp.rvalid = 1'b1;
    end

    // Tool counter and warnings
    if (clr_tool) begin
      next_r.tool_count = '0;
    end else if (status.measure_done) begin
      next_r.tool_count = r.tool_count + 32'h00000001;
    end
    next_r.tool_warn = (next_r.tool_count >= r.tool_limit);
    next_r.tare_warn = (status.tare_value >= r.tare_limit);

    // Sticky events on rising warnings; a set beats the read clear
    ev[IRQ_TOOL] = next_r.tool_warn & ~r.tool_warn;
    ev[IRQ_TARE] = next_r.tare_warn & ~r.tare_warn;
    ev[IRQ_TOTAL] = (next_r.tool_warn | next_r.tare_warn | status.other_warning)
                    & ~total_warn;
    if (do_read && ra == ADDR_IRQ_STATUS) begin
      next_r.irq_status = ev;
    end else begin
      next_r.irq_status = r.irq_status | ev;
    end
    next_r.irq = |(next_r.irq_status & r.irq_mask);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.sel <= SEL_DEFAULT;
      r.tool_limit <= TOOL_LIMIT_RESET;
      r.tare_limit <= TARE_LIMIT_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign axi_rsp = r.rsp;
  assign plc_out = r.plc_out;
  assign irq = r.irq;

endmodule : posr_router

// ### sim/posr_properties.sv
// Checker on the router ports: bus timing and reset state
`timescale 1ns/1ps
module posr_properties
  import posr_pkg::*;
#(
  parameter int OUTPUTS = NUM_OUTPUTS,
  parameter int FLASH_CYCLES = FLASH_HALF_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire posr_status_type status,
  input wire posr_axi_req_type axi_req,
  input wire posr_axi_rsp_type axi_rsp,
  input wire logic [OUTPUTS-1:0] plc_out,
  input wire logic irq
);
  // ------
  // Properties
  // ------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid)
    else $error("write response dropped early");
  rdata_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready |=>
    axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data not held");
  write_answer_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
    && axi_rsp.wready |-> ##[1:2] axi_rsp.bvalid) else $error("write response missing");
  read_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read response late");
  awready_pulse_a: assert property (axi_rsp.awready |=> !axi_rsp.awready)
    else $error("awready longer than one cycle");
  arready_pulse_a: assert property (axi_rsp.arready |=> !axi_rsp.arready)
    else $error("arready longer than one cycle");
  err_data_a: assert property (axi_rsp.rvalid && axi_rsp.rresp == 2'b10 |->
    axi_rsp.rdata == 32'h0) else $error("refused read returned data");
  reset_low_a: assert property ($rose(aresetn) |-> plc_out == '0 && !irq)
    else $error("outputs not low after reset");
  write_done_c: cover property (axi_rsp.bvalid && axi_req.bready);
  read_done_c: cover property (axi_rsp.rvalid && axi_req.rready);
  irq_rise_c: cover property ($rose(irq));
endmodule : posr_properties

bind posr_router posr_properties #(.OUTPUTS(OUTPUTS), .FLASH_CYCLES(FLASH_CYCLES))
  posr_properties_i (.aclk(aclk), .aresetn(aresetn), .status(status), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .plc_out(plc_out), .irq(irq));

// ### sim/posr_plc_model.sv
// Controller-side model latching the echoed program number
`timescale 1ns/1ps
module posr_plc_model
  import posr_pkg::*;
(
  input wire logic aclk,
  input wire logic [NUM_OUTPUTS-1:0] plc_in,
  output logic [4:0] prog_seen
);
  // Fixed to factory positions; echo bits may be mid-change without the strobe
  always_ff @(posedge aclk) begin
    if (plc_in[0]) begin
      prog_seen <= plc_in[7:3];
    end
  end
endmodule : posr_plc_model

// ### sim/tb_plc_output_signal_router.sv
// Self-checking testbench for the controller output router
`timescale 1ns/1ps
module tb_plc_output_signal_router;
  import posr_pkg::*;
  // ------
  // Signals
  // ------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  posr_status_type st;
  posr_axi_req_type q = '0;
  posr_axi_rsp_type p;
  logic [22:0] plc;
  logic irq;
  logic [4:0] seen;
  logic [1:0] rs;
  logic [31:0] rd;
  logic tare_w = 1'b0;
  logic tool_w = 1'b0;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  int hi = 0;
  logic [22:0] eo;
  localparam logic [5:0] DFLT [23] = '{6'h03, 6'h0e, 6'h1f, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08,
    6'h01, 6'h02, 6'h1e, 6'h1d, 6'h1c, 6'h1b, 6'h1a, 6'h19, 6'h18, 6'h17, 6'h0b, 6'h0c, 6'h0d,
    6'h0f, 6'h10};
  logic [5:0] sel [23] = DFLT;
  localparam posr_status_type PAT = 73'h1_2b9c_3a5e_15a3_c96a_5d;

  posr_router #(.OUTPUTS(23), .FLASH_CYCLES(4)) posr_router_i (.aclk(aclk), .aresetn(aresetn),
    .status(st), .axi_req(q), .axi_rsp(p), .plc_out(plc), .irq(irq));
  posr_plc_model posr_plc_model_i (.aclk(aclk), .plc_in(plc), .prog_seen(seen));

  initial forever #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end
  // ------
  // Tasks
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  // Tare, pulse and prompt bits cleared so warnings stay predictable
  task automatic set_pat(input logic inv);
    posr_status_type t;
    t = inv ? ~PAT : PAT;
    t.tare_value = '0;
    t.measure_done = 1'b0;
    t.other_warning = 1'b0;
    t.ack_pending_pass = 1'b0;
    t.ack_pending_fail = 1'b0;
    st <= t;
  endtask : set_pat
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aok, wok, bok;
    @(posedge aclk);
    q.awaddr <= {24'h0, a};
    q.wdata <= d;
    q.wstrb <= 4'hf;
    q.awvalid <= 1'b1;
    q.wvalid <= 1'b1;
    q.bready <= 1'b1;
    do begin
      @(negedge aclk);
      aok = p.awready;
      wok = p.wready;
      bok = p.bvalid;
      rs = p.bresp;
      @(posedge aclk);
      if (aok) q.awvalid <= 1'b0;
      if (wok) q.wvalid <= 1'b0;
    end while (!bok);
    q.bready <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    logic aok, rok;
    @(posedge aclk);
    q.araddr <= {24'h0, a};
    q.arvalid <= 1'b1;
    q.rready <= 1'b1;
    do begin
      @(negedge aclk);
      aok = p.arready;
      rok = p.rvalid;
      rd = p.rdata;
      rs = p.rresp;
      @(posedge aclk);
      if (aok) q.arvalid <= 1'b0;
    end while (!rok);
    q.rready <= 1'b0;
  endtask : rd_reg
  task automatic check_out();
    logic [63:0] v;
    logic [22:0] e;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    v = {23'h0, st.threshold_fail, st.trapezoid_fail, st.window_fail, st.ack_fail, st.ack_pass,
      st.ack_lock, st.ack_alarm, st.config_mode, st.measuring_now, st.complex_test_active,
      st.simple_test_active, st.sensor_test_pass, tare_w | tool_w | st.other_warning, tool_w,
      tare_w, st.prog_number & {7{st.prog_valid}}, st.prog_valid, st.switch_s4, st.switch_s3, 1'b0};
    for (int k = 0; k < 23; k++) e[k] = v[sel[k]];
    eo = e;
    chk({9'h0, plc}, {9'h0, e});
  endtask : check_out
  // ------
  // Sequence
  // ------
  initial begin
    set_pat(1'b0);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    check_out();
    chk({27'h0, seen}, {27'h0, PAT.prog_number[4:0]});
    rd_reg(ADDR_TOOL_LIMIT);
    chk(rd, TOOL_LIMIT_RESET);
    for (int c = 0; c < 48; c++) begin
      sel[c % 23] = 6'(c);
      wr(ADDR_SEL_BASE + 8'(4 * (c % 23)), 32'(c));
      rd_reg(ADDR_SEL_BASE + 8'(4 * (c % 23)));
      chk(rd, 32'(c));
      set_pat(1'b0);
      check_out();
      set_pat(1'b1);
      check_out();
    end
    wr(8'h5c, 32'h1);
    chk({30'h0, rs}, 32'h2);
    rd_reg(8'h5c);
    chk({rd[29:0], rs}, 32'h2);
    sel[0] = 6'h0c;
    sel[1] = 6'h0d;
    sel[2] = 6'h0b;
    wr(ADDR_SEL_BASE, 32'hc);
    wr(ADDR_SEL_BASE + 8'h4, 32'hd);
    wr(ADDR_SEL_BASE + 8'h8, 32'hb);
    wr(ADDR_IRQ_MASK, 32'h1);
    wr(ADDR_TOOL_LIMIT, 32'h3);
    wr(ADDR_TARE_LIMIT, 32'h100);
    set_pat(1'b0);
    for (int i = 0; i < 3; i++) begin
      @(posedge aclk);
      st.measure_done <= 1'b1;
      @(posedge aclk);
      st.measure_done <= 1'b0;
      tool_w = (i == 2);
      check_out();
    end
    chk({31'h0, irq}, 32'h1);
    rd_reg(ADDR_TOOL_COUNT);
    chk(rd, 32'h3);
    rd_reg(ADDR_IRQ_STATUS);
    chk(rd, 32'h5);
    wr(ADDR_CTRL, 32'h1);
    tool_w = 1'b0;
    check_out();
    chk({31'h0, irq}, 32'h0);
    @(posedge aclk);
    st.tare_value <= 32'hff;
    check_out();
    @(posedge aclk);
    st.tare_value <= 32'h100;
    tare_w = 1'b1;
    check_out();
    rd_reg(ADDR_OUT_STATE);
    chk(rd, {9'h0, eo});
    rd_reg(ADDR_IRQ_STATUS);
    chk(rd, 32'h6);
    @(negedge aclk);
    chk({31'h0, irq}, 32'h0);
    // Flash half period is 4 cycles here, so any 8 samples hold 4 highs
    sel[3] = 6'h15;
    wr(ADDR_SEL_BASE + 8'hc, 32'h15);
    wr(ADDR_CTRL, 32'h2);
    st.ack_pending_pass <= 1'b1;
    repeat (3) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      @(negedge aclk);
      hi += plc[3];
    end
    chk(32'(hi), 32'h4);
    @(posedge aclk);
    st.ack_pending_pass <= 1'b0;
    check_out();
    // Reset in mid-run brings back factory selections and limits
    @(posedge aclk);
    aresetn <= 1'b0;
    set_pat(1'b0);
    tare_w = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    sel = DFLT;
    check_out();
    chk({31'h0, irq}, 32'h0);
    rd_reg(ADDR_TARE_LIMIT);
    chk(rd, TARE_LIMIT_RESET);
    rd_reg(ADDR_CTRL);
    chk(rd, 32'h0);
    test_done();
  end
endmodule : tb_plc_output_signal_router
